// >>> logic/lualm_pkg.sv
// Package of constants and types for the line unit alarm and status block
package lualm_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] LUALM_OFF_CTRL = 12'h000;
  localparam logic [11:0] LUALM_OFF_STAT = 12'h004;
  localparam logic [11:0] LUALM_OFF_CNT = 12'h008;
  localparam int LUALM_CTRL_ALM_EN = 0;
  localparam int LUALM_CTRL_ES_LSB = 1;
  localparam int LUALM_CTRL_MG_LSB = 4;
  localparam logic [31:0] LUALM_CTRL_RESET = 32'h0000_0040;
  localparam logic [3:0] LUALM_MARGIN_DEFAULT = 4'h4;
  // ****************************************************************
  // Thresholds and timing
  // ****************************************************************
  localparam logic [1:0] LUALM_ES_NONE = 2'h0;
  localparam logic [1:0] LUALM_ES_17 = 2'h1;
  localparam logic [1:0] LUALM_ES_170 = 2'h2;
  localparam logic [15:0] LUALM_ES_LOW = 16'h0011;
  localparam logic [15:0] LUALM_ES_HIGH = 16'h00AA;
  localparam longint LUALM_CLK_HZ = 25000000;
  localparam longint LUALM_DAY_S = 86400;
  localparam longint LUALM_DAY_CYC = LUALM_CLK_HZ * LUALM_DAY_S;
  localparam longint LUALM_FLASH_MS = 500;
  localparam longint LUALM_FLASH_CYC = LUALM_CLK_HZ * LUALM_FLASH_MS / 1000;
  typedef enum logic [2:0] {
    LUALM_MSG_NONE, LUALM_MSG_SYNC, LUALM_MSG_LOCAL_SIGNAL_LOSS, LUALM_MSG_REMOTE_SIGNAL_LOSS,
    LUALM_MSG_ES1, LUALM_MSG_ES2, LUALM_MSG_BPV, LUALM_MSG_MARGIN
  } lualm_msg_t;
  typedef enum logic [1:0] {
    LUALM_LED_OFF, LUALM_LED_GREEN, LUALM_LED_RED, LUALM_LED_YELLOW
  } lualm_led_t;
endpackage

// >>> logic/lualm_top.sv
// Line unit alarm ranking, cut-off, status LED and AXI4-Lite registers
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module lualm_top
  import lualm_pkg::*;
#(
  parameter longint DAY_CYC = lualm_pkg::LUALM_DAY_CYC,
  parameter longint FLASH_CYC = lualm_pkg::LUALM_FLASH_CYC
)
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // AXI4-Lite slave
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Line monitors
  input wire logic [1:0] SYNC_LOSS,
  input wire logic LOCAL_SIGNAL_LOSS,
  input wire logic REMOTE_SIGNAL_LOSS,
  input wire logic [1:0] ERRSEC_PULSE,
  input wire logic BIPOLAR_VIOLATION_LOCAL,
  input wire logic BIPOLAR_VIOLATION_REMOTE,
  input wire logic [3:0] LOOP1_MARGIN,
  input wire logic [3:0] LOOP2_MARGIN,
  input wire logic ACQUIRING,
  input wire logic SELF_TEST,
  input wire logic REMOTE_SIDE_LOOPBACK,
  input wire logic NETWORK_LOCAL_LOOPBACK,
  input wire logic FUSE_OPEN,
  input wire logic SELECT_PRESS,
  // Alarm and panel outputs
  output logic MINOR_ALARM_OUT_O,
  output logic MINOR_ALARM_OUT_OE,
  output logic FUSE_ALARM_OUT_O,
  output logic FUSE_ALARM_OUT_OE,
  output lualm_pkg::lualm_msg_t MSG_CODE,
  output logic MSG_CUTOFF,
  output lualm_pkg::lualm_led_t LED_COLOR
);
  import lualm_pkg::*;

  // ****************************************************************
  // Reset synchroniser and configuration
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge CLK_SYS or negedge RST_N)
    if (!RST_N)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  assign rst_n = rst_sync_q[1];

  logic [31:0] ctrl_q;
  logic alarm_output_enable;
  logic [1:0] errsec_threshold_setting;
  logic [3:0] margin_threshold_setting;
  assign alarm_output_enable = ctrl_q[LUALM_CTRL_ALM_EN];
  assign errsec_threshold_setting = ctrl_q[LUALM_CTRL_ES_LSB +: 2];
  assign margin_threshold_setting = ctrl_q[LUALM_CTRL_MG_LSB +: 4];

  // ****************************************************************
  // Daily counters
  // ****************************************************************
  logic [36:0] day_q;
  logic day_end;
  logic [15:0] es_cnt_q [2];
  logic [15:0] bpv_cnt_q;
  logic [15:0] es_limit;
  assign day_end = (day_q == 37'(DAY_CYC - 1));
  always_ff @(posedge CLK_SYS or negedge rst_n)
    if (!rst_n)
      day_q <= 37'h0;
    else if (day_end)
      day_q <= 37'h0;
    else
      day_q <= day_q + 37'h1;

  function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic [1:0] n);
    sat_inc = (v > 16'hFFFD) ? 16'hFFFF : v + {14'h0, n};
  endfunction

  for (genvar i = 0; i < 2; i++)
  begin : g_es
    always_ff @(posedge CLK_SYS or negedge rst_n)
      if (!rst_n)
        es_cnt_q[i] <= 16'h0;
      else if (day_end)
        es_cnt_q[i] <= 16'h0;
      else if (ERRSEC_PULSE[i])
        es_cnt_q[i] <= sat_inc(es_cnt_q[i], 2'h1);
  end

  always_ff @(posedge CLK_SYS or negedge rst_n)
    if (!rst_n)
      bpv_cnt_q <= 16'h0;
    else if (day_end)
      bpv_cnt_q <= 16'h0;
    else
      bpv_cnt_q <= sat_inc(bpv_cnt_q,
        {1'b0, BIPOLAR_VIOLATION_LOCAL} + {1'b0, BIPOLAR_VIOLATION_REMOTE});

  always_comb
    unique case (errsec_threshold_setting)
      LUALM_ES_17: es_limit = LUALM_ES_LOW;
      LUALM_ES_170: es_limit = LUALM_ES_HIGH;
      default: es_limit = 16'hFFFF;
    endcase

  // ****************************************************************
  // Alarm conditions and ranking
  // ****************************************************************
  logic es_on;
  logic sync_loss_alarm;
  logic loop1_errsec_alarm;
  logic loop2_errsec_alarm;
  logic bpv_alarm;
  logic loop1_margin_alarm;
  logic loop2_margin_alarm;
  logic any_alarm;
  lualm_msg_t msg_d;
  assign es_on = (errsec_threshold_setting != LUALM_ES_NONE);
  assign sync_loss_alarm = |SYNC_LOSS;
  assign loop1_errsec_alarm = es_on && (es_cnt_q[0] > es_limit);
  assign loop2_errsec_alarm = es_on && (es_cnt_q[1] > es_limit);
  assign bpv_alarm = es_on && (bpv_cnt_q > es_limit);
  assign loop1_margin_alarm = LOOP1_MARGIN < margin_threshold_setting;
  assign loop2_margin_alarm = LOOP2_MARGIN < margin_threshold_setting;
  assign any_alarm = msg_d != LUALM_MSG_NONE;

  always_comb
  begin
    if (sync_loss_alarm)
      msg_d = LUALM_MSG_SYNC;
    else if (LOCAL_SIGNAL_LOSS)
      msg_d = LUALM_MSG_LOCAL_SIGNAL_LOSS;
    else if (REMOTE_SIGNAL_LOSS)
      msg_d = LUALM_MSG_REMOTE_SIGNAL_LOSS;
    else if (loop1_errsec_alarm)
      msg_d = LUALM_MSG_ES1;
    else if (loop2_errsec_alarm)
      msg_d = LUALM_MSG_ES2;
    else if (bpv_alarm)
      msg_d = LUALM_MSG_BPV;
    else if (loop1_margin_alarm || loop2_margin_alarm)
      msg_d = LUALM_MSG_MARGIN;
    else
      msg_d = LUALM_MSG_NONE;
  end

  // ****************************************************************
  // Message and cut-off
  // ****************************************************************
  logic cutoff_q;
  always_ff @(posedge CLK_SYS or negedge rst_n)
    if (!rst_n)
      MSG_CODE <= LUALM_MSG_NONE;
    else
      MSG_CODE <= msg_d;

  always_ff @(posedge CLK_SYS or negedge rst_n)
    if (!rst_n)
      cutoff_q <= 1'b0;
    else if (!alarm_output_enable)
      cutoff_q <= 1'b0;
    else if (msg_d != MSG_CODE)
      cutoff_q <= 1'b0;
    else if (SELECT_PRESS && any_alarm)
      cutoff_q <= 1'b1;
  assign MSG_CUTOFF = cutoff_q;

  // ****************************************************************
  // Alarm pins
  // ****************************************************************
  always_ff @(posedge CLK_SYS or negedge rst_n)
    if (!rst_n)
    begin
      MINOR_ALARM_OUT_OE <= 1'b0;
      FUSE_ALARM_OUT_OE <= 1'b0;
    end
    else
    begin
      MINOR_ALARM_OUT_OE <= any_alarm && alarm_output_enable
        && !(cutoff_q && msg_d == MSG_CODE) && !(SELECT_PRESS && msg_d == MSG_CODE);
      FUSE_ALARM_OUT_OE <= FUSE_OPEN;
    end
  assign MINOR_ALARM_OUT_O = 1'b0;
  assign FUSE_ALARM_OUT_O = 1'b0;

  // ****************************************************************
  // Status LED
  // ****************************************************************
  logic [31:0] flash_cnt_q;
  logic blink_q;
  always_ff @(posedge CLK_SYS or negedge rst_n)
    if (!rst_n)
    begin
      flash_cnt_q <= 32'h0;
      blink_q <= 1'b0;
    end
    else if (flash_cnt_q == 32'(FLASH_CYC - 1))
    begin
      flash_cnt_q <= 32'h0;
      blink_q <= ~blink_q;
    end
    else
      flash_cnt_q <= flash_cnt_q + 32'h1;

  always_ff @(posedge CLK_SYS or negedge rst_n)
    if (!rst_n)
      LED_COLOR <= LUALM_LED_OFF;
    else if (FUSE_OPEN)
      LED_COLOR <= LUALM_LED_RED;
    else if (any_alarm)
      LED_COLOR <= blink_q ? LUALM_LED_RED : LUALM_LED_OFF;
    else if (SELF_TEST || REMOTE_SIDE_LOOPBACK || NETWORK_LOCAL_LOOPBACK)
      LED_COLOR <= LUALM_LED_YELLOW;
    else if (ACQUIRING)
      LED_COLOR <= blink_q ? LUALM_LED_GREEN : LUALM_LED_OFF;
    else
      LED_COLOR <= LUALM_LED_GREEN;

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic aw_q;
  logic w_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_wr;
  assign S_AXI_AWREADY = !aw_q && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_q && !S_AXI_BVALID;
  assign do_wr = aw_q && w_q;
  always_ff @(posedge CLK_SYS or negedge rst_n)
    if (!rst_n)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 12'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'h0;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (do_wr)
      begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (awaddr_q[11:2] == LUALM_OFF_CTRL[11:2]) ? 2'h0 : 2'h2;
      end
      else if (S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end

  always_ff @(posedge CLK_SYS or negedge rst_n)
    if (!rst_n)
      ctrl_q <= LUALM_CTRL_RESET;
    else if (do_wr && awaddr_q[11:2] == LUALM_OFF_CTRL[11:2])
      for (int b = 0; b < 4; b++)
        if (wstrb_q[b])
          ctrl_q[b*8 +: 8] <= wdata_q[b*8 +: 8] & 8'(32'h0000_007F >> (b*8));

  assign S_AXI_ARREADY = !S_AXI_RVALID;
  always_ff @(posedge CLK_SYS or negedge rst_n)
    if (!rst_n)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= 2'h0;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= 2'h0;
      unique case (S_AXI_ARADDR[11:2])
        LUALM_OFF_CTRL[11:2]: S_AXI_RDATA <= ctrl_q;
        LUALM_OFF_STAT[11:2]: S_AXI_RDATA <= {19'h0, FUSE_OPEN, LED_COLOR, cutoff_q,
          MINOR_ALARM_OUT_OE, MSG_CODE, loop2_margin_alarm, loop1_margin_alarm,
          bpv_alarm, loop2_errsec_alarm, loop1_errsec_alarm};
        LUALM_OFF_CNT[11:2]: S_AXI_RDATA <= {bpv_cnt_q, es_cnt_q[0][7:0], es_cnt_q[1][7:0]};
        default:
        begin
          S_AXI_RDATA <= 32'h0;
          S_AXI_RRESP <= 2'h2;
        end
      endcase
    end
    else if (S_AXI_RREADY)
      S_AXI_RVALID <= 1'b0;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_sync_top;
    @(posedge CLK_SYS) disable iff (!rst_n) sync_loss_alarm |=> MSG_CODE == LUALM_MSG_SYNC;
  endproperty
  a_sync_top: assert property (p_sync_top) else $error("sync loss not shown");
  property p_local_signal_loss;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (!sync_loss_alarm && LOCAL_SIGNAL_LOSS) |=> MSG_CODE == LUALM_MSG_LOCAL_SIGNAL_LOSS;
  endproperty
  a_local_signal_loss: assert property (p_local_signal_loss) else $error("local loss rank wrong");
  property p_rank;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (!sync_loss_alarm && !LOCAL_SIGNAL_LOSS && REMOTE_SIGNAL_LOSS)
        |=> MSG_CODE == LUALM_MSG_REMOTE_SIGNAL_LOSS;
  endproperty
  a_rank: assert property (p_rank) else $error("remote loss rank wrong");
  property p_dis_off;
    @(posedge CLK_SYS) disable iff (!rst_n) !alarm_output_enable |=> !MINOR_ALARM_OUT_OE;
  endproperty
  a_dis_off: assert property (p_dis_off) else $error("alarm driven while disabled");
  property p_dis_aco;
    @(posedge CLK_SYS) disable iff (!rst_n) !alarm_output_enable |=> !cutoff_q;
  endproperty
  a_dis_aco: assert property (p_dis_aco) else $error("cut-off kept while disabled");
  property p_fuse;
    @(posedge CLK_SYS) disable iff (!rst_n)
      FUSE_OPEN |=> FUSE_ALARM_OUT_OE && LED_COLOR == LUALM_LED_RED;
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse alarm missing");
  property p_drive;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (any_alarm && alarm_output_enable && !cutoff_q && !SELECT_PRESS) |=> MINOR_ALARM_OUT_OE;
  endproperty
  a_drive: assert property (p_drive) else $error("minor alarm not grounded");
  property p_es_none;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (errsec_threshold_setting == LUALM_ES_NONE) |-> !loop1_errsec_alarm && !bpv_alarm;
  endproperty
  a_es_none: assert property (p_es_none) else $error("errored alarm with none");
  c_cutoff: cover property (@(posedge CLK_SYS) disable iff (!rst_n) $rose(cutoff_q));
  c_es1: cover property (@(posedge CLK_SYS) disable iff (!rst_n) loop1_errsec_alarm);
  c_margin: cover property (@(posedge CLK_SYS) disable iff (!rst_n)
    MSG_CODE == LUALM_MSG_MARGIN);
endmodule
`default_nettype wire

// >>> testbench/lualm_panel.sv
// Panel and alarm bus model: pulled-up alarm lines and select button
`timescale 1ns/10ps
`default_nettype none
module lualm_panel
(
  // Clock
  input wire logic clk,
  // Open-drain outputs of the block
  input wire logic minor_o,
  input wire logic minor_oe,
  input wire logic fuse_o,
  input wire logic fuse_oe,
  // Bus levels and button
  output logic minor_line,
  output logic fuse_line,
  output var logic sel
);
  // Lines pulled up, follow the pin only while driven
  assign minor_line = minor_oe ? minor_o : 1'b1;
  assign fuse_line = fuse_oe ? fuse_o : 1'b1;
  initial sel = 1'b0;
  // One-cycle debounced press
  task automatic press();
    sel <= 1'b1;
    @(posedge clk);
    sel <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> testbench/lualm_top_tb.sv
// Self-checking bench for the line unit alarm and status block
`timescale 1ns/10ps
`default_nettype none
module lualm_top_tb;
  import lualm_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam longint DAY = 3000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [1:0] sync = 2'h0;
  logic [1:0] espul = 2'h0;
  logic local_signal_loss = 1'b0;
  logic remote_signal_loss = 1'b0;
  logic bpvl = 1'b0;
  logic bpvr = 1'b0;
  logic [3:0] mg1 = 4'hF;
  logic [3:0] mg2 = 4'hF;
  logic acq = 1'b0;
  logic tst = 1'b0;
  logic lbr = 1'b0;
  logic lbn = 1'b0;
  logic fuse = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sel, mo, moe, fo, foe, cut, mline, fline;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, rd;
  lualm_msg_t msg;
  lualm_led_t led;
  int n;
  int miscompares = 0;
  int tests_run = 0;
  always #20 clk = ~clk;
  // ****************************************************************
  // Design and panel model
  // ****************************************************************
  lualm_top #(.DAY_CYC(DAY), .FLASH_CYC(4)) i_lualm_top (
    .CLK_SYS(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SYNC_LOSS(sync), .LOCAL_SIGNAL_LOSS(local_signal_loss), .REMOTE_SIGNAL_LOSS(remote_signal_loss),
    .ERRSEC_PULSE(espul), .BIPOLAR_VIOLATION_LOCAL(bpvl), .BIPOLAR_VIOLATION_REMOTE(bpvr),
    .LOOP1_MARGIN(mg1), .LOOP2_MARGIN(mg2), .ACQUIRING(acq), .SELF_TEST(tst),
    .REMOTE_SIDE_LOOPBACK(lbr), .NETWORK_LOCAL_LOOPBACK(lbn), .FUSE_OPEN(fuse),
    .SELECT_PRESS(sel), .MINOR_ALARM_OUT_O(mo), .MINOR_ALARM_OUT_OE(moe),
    .FUSE_ALARM_OUT_O(fo), .FUSE_ALARM_OUT_OE(foe), .MSG_CODE(msg), .MSG_CUTOFF(cut),
    .LED_COLOR(led));
  lualm_panel i_lualm_panel (.clk(clk), .minor_o(mo), .minor_oe(moe), .fuse_o(fo),
    .fuse_oe(foe), .minor_line(mline), .fuse_line(fline), .sel(sel));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic complete_run();
    $display("counts: %0d compared, %0d mismatched", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo();
    miscompares++;
    complete_run();
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
    int k;
    bit ok;
    k = 0;
    ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!ok && k < 100)
    begin
      @(posedge clk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        rs = bresp;
        bready <= 1'b0;
        ok = 1'b1;
      end
    end
    if (!ok) tmo();
  endtask
  task automatic rdt(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
    int k;
    bit ok;
    k = 0;
    ok = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!ok && k < 100)
    begin
      @(posedge clk);
      k++;
      if (arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
        ok = 1'b1;
      end
    end
    if (!ok) tmo();
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] m,
    input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] rs;
    rdt(a, d, rs);
    chk(nm, e, d & m);
  endtask
  task automatic pulse(input int k, input logic [1:0] e, input logic b);
    repeat (k)
    begin
      espul <= e;
      bpvl <= b;
      bpvr <= b;
      @(posedge clk);
      espul <= 2'h0;
      bpvl <= 1'b0;
      bpvr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic flash(input lualm_led_t c);
    int on;
    int off;
    on = 0;
    off = 0;
    repeat (12)
    begin
      @(posedge clk);
      if (led === c) on++;
      if (led === LUALM_LED_OFF) off++;
    end
    chk("flash", 32'h1, {31'h0, (on > 0) && (off > 0)});
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    step(3);
    rst_n <= 1'b1;
    step(4);
    rdchk("ctrl", 12'h000, 32'hFFFF_FFFF, 32'h0000_0040);
    wr(12'h004, 32'h0000_0001, r);
    chk("bresp", 32'h2, r);
    rdt(12'h00C, rd, r);
    chk("rresp", 32'h2, r);
    chk("led", LUALM_LED_GREEN, led);
    $display("test reset done");
    acq <= 1'b1;
    flash(LUALM_LED_GREEN);
    tst <= 1'b1;
    step(3);
    chk("led", LUALM_LED_YELLOW, led);
    tst <= 1'b0;
    lbr <= 1'b1;
    step(3);
    chk("led", LUALM_LED_YELLOW, led);
    lbr <= 1'b0;
    lbn <= 1'b1;
    step(3);
    chk("led", LUALM_LED_YELLOW, led);
    lbn <= 1'b0;
    acq <= 1'b0;
    $display("test led done");
    pulse(18, 2'h3, 1'b0);
    step(3);
    chk("msg", LUALM_MSG_NONE, msg);
    wr(12'h000, 32'h0000_0044, r);
    step(3);
    chk("msg", LUALM_MSG_NONE, msg);
    wr(12'h000, 32'h0000_0042, r);
    step(3);
    chk("msg", LUALM_MSG_ES1, msg);
    pulse(8, 2'h0, 1'b1);
    rdchk("stat", 12'h004, 32'h1F, 32'h03);
    pulse(1, 2'h0, 1'b1);
    rdchk("stat", 12'h004, 32'h1F, 32'h07);
    rdchk("cnt", 12'h008, 32'hFFFF_FFFF, 32'h0012_1212);
    $display("test errsec done");
    mg2 <= 4'h4;
    rdchk("stat", 12'h004, 32'h1F, 32'h07);
    mg2 <= 4'h3;
    mg1 <= 4'h3;
    rdchk("stat", 12'h004, 32'h1F, 32'h1F);
    wr(12'h000, 32'h0000_0032, r);
    rdchk("stat", 12'h004, 32'h1F, 32'h07);
    wr(12'h000, 32'h0000_0042, r);
    mg1 <= 4'hF;
    mg2 <= 4'hF;
    $display("test margin done");
    remote_signal_loss <= 1'b1;
    step(3);
    chk("msg", LUALM_MSG_REMOTE_SIGNAL_LOSS, msg);
    local_signal_loss <= 1'b1;
    step(3);
    chk("msg", LUALM_MSG_LOCAL_SIGNAL_LOSS, msg);
    sync <= 2'h2;
    step(3);
    chk("msg", LUALM_MSG_SYNC, msg);
    sync <= 2'h0;
    local_signal_loss <= 1'b0;
    step(3);
    chk("msg", LUALM_MSG_REMOTE_SIGNAL_LOSS, msg);
    remote_signal_loss <= 1'b0;
    step(3);
    chk("msg", LUALM_MSG_ES1, msg);
    $display("test priority done");
    chk("minor oe", 32'h0, moe);
    flash(LUALM_LED_RED);
    wr(12'h000, 32'h0000_0043, r);
    step(2);
    chk("minor line", 32'h0, mline);
    i_lualm_panel.press();
    step(2);
    chk("minor oe", 32'h0, moe);
    chk("cutoff", 32'h1, cut);
    chk("msg", LUALM_MSG_ES1, msg);
    sync <= 2'h1;
    step(3);
    chk("msg", LUALM_MSG_SYNC, msg);
    chk("cutoff", 32'h0, cut);
    chk("minor oe", 32'h1, moe);
    i_lualm_panel.press();
    step(2);
    chk("cutoff", 32'h1, cut);
    wr(12'h000, 32'h0000_0042, r);
    step(2);
    chk("cutoff", 32'h0, cut);
    chk("minor oe", 32'h0, moe);
    sync <= 2'h0;
    $display("test cutoff done");
    fuse <= 1'b1;
    step(3);
    chk("fuse line", 32'h0, fline);
    chk("led", LUALM_LED_RED, led);
    step(5);
    chk("led", LUALM_LED_RED, led);
    fuse <= 1'b0;
    step(3);
    chk("fuse oe", 32'h0, foe);
    $display("test fuse done");
    n = 0;
    rd = 32'h1;
    while (rd !== 32'h0 && n < 40)
    begin
      step(100);
      rdt(12'h008, rd, r);
      n++;
    end
    chk("cnt", 32'h0, rd);
    step(3);
    chk("msg", LUALM_MSG_NONE, msg);
    $display("test day done");
    complete_run();
  end
endmodule
`default_nettype wire
